// ===== dv/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, fwd_run, near_full, swap_done;
  logic rev, pblk, dhold, dinit;
  logic [7:0] awaddr, araddr, di;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [1:0] bresp_seen;
  logic signed [31:0] main_pct, pid_pct, diam_pct, ten_pct, fric_pct, spd, trq, dinit_pct;
  int mismatches, total_checks;
  ////////////////////////////////////////////////////////////////////////////////
  wfs_top #(.TICK_CYC(4)) u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .di_in(di), .fwd_run(fwd_run), .main_speed_pct(main_pct), .pid_out_pct(pid_pct),
    .diam_est_pct(diam_pct), .tension_cmd_pct(ten_pct), .friction_loss_pct(fric_pct),
    .speed_cmd_hz(spd), .run_reverse(rev), .torque_cmd_pct(trq), .pid_block(pblk),
    .diam_calc_hold(dhold), .diam_init(dinit), .diam_init_pct(dinit_pct)
  );
  wfs_splice_ctl #(.DI_IDX(0)) u_ctl (
    .aclk(aclk), .aresetn(aresetn), .near_full(near_full), .swap_done(swap_done), .di_out(di)
  );
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk
  // ready is a flop, so its level at the falling edge is what the next rising edge sees
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_pend, w_pend, aw_hit, w_hit, b_hit;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_pend = 1'b1;
    w_pend = 1'b1;
    b_hit = 1'b0;
    while (!b_hit) begin
      @(negedge aclk);
      aw_hit = aw_pend && awready;
      w_hit = w_pend && wready;
      b_hit = bvalid;
      bresp_seen = bresp;
      @(posedge aclk);
      awvalid <= aw_pend && !aw_hit;
      aw_pend = aw_pend && !aw_hit;
      wvalid <= w_pend && !w_hit;
      w_pend = w_pend && !w_hit;
      bready <= !b_hit;
    end
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_pend, ar_hit, r_hit;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    ar_pend = 1'b1;
    r_hit = 1'b0;
    while (!r_hit) begin
      @(negedge aclk);
      ar_hit = ar_pend && arready;
      r_hit = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      arvalid <= ar_pend && !ar_hit;
      ar_pend = ar_pend && !ar_hit;
      rready <= !r_hit;
    end
  endtask : axi_rd
  task automatic set_in(input logic signed [31:0] m, input logic signed [31:0] p,
                        input logic signed [31:0] dm);
    @(posedge aclk);
    main_pct <= m;
    pid_pct <= p;
    diam_pct <= dm;
  endtask : set_in
  // bounded wait for the speed or the torque output to settle on a value
  task automatic wait_val(input bit sel_trq, input logic signed [31:0] exp,
                          output logic [31:0] seen);
    int n;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
      seen = sel_trq ? trq : spd;
    end while (seen !== exp && n < 600);
  endtask : wait_val
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [7:0] offs [4] = '{8'h00, 8'h04, 8'h08, 8'h0C};
    logic [31:0] vals [4] = '{32'h0000_0001, 32'h0000_0000, 32'h0000_0000, 32'h0000_2710};
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 4; i++) begin
      axi_rd(offs[i], d, r);
      chk(d, vals[i], "reset value");
    end
    axi_rd(8'h80, d, r);
    chk({d, r} == {32'h0000_0000, 2'b10}, 1'b1, "unmapped read");
    axi_wr(8'h80, 32'h0000_FFFF);
    chk(bresp_seen, 32'h0000_0002, "unmapped write");
    $display("test regs done");
  endtask : t_regs
  task automatic t_norm();
    logic [31:0] s;
    axi_wr(8'h28, 32'h0000_000A);
    chk(bresp_seen, 32'h0000_0000, "write okay");
    axi_wr(8'h2C, 32'h0000_000A);
    set_in(32'sh0000_1388, 32'sh0000_0000, 32'sh0000_2710);
    repeat (8) @(negedge aclk);
    chk(spd < 32'sh0000_0258, 1'b1, "speed stepped");
    wait_val(1'b0, 32'sh0000_0258, s);
    chk(s, 32'h0000_0258, "normal speed");
    set_in(32'sh0000_1388, 32'sh0000_0000, 32'sh0000_1388);
    wait_val(1'b0, 32'sh0000_04B0, s);
    chk(s, 32'h0000_04B0, "half diameter");
    $display("test normal done");
  endtask : t_norm
  task automatic t_rev();
    logic [31:0] s;
    set_in(32'sh0000_03E8, -32'sh0000_0BB8, 32'sh0000_2710);
    wait_val(1'b0, 32'sh0000_0168, s);
    chk(s, 32'h0000_0168, "reverse speed");
    chk(rev, 1'b1, "reverse flag");
    axi_wr(8'h00, 32'h0000_0000);
    wait_val(1'b0, 32'sh0000_0000, s);
    chk(s, 32'h0000_0000, "clamped speed");
    chk(rev, 1'b0, "reverse flag off");
    $display("test reverse done");
  endtask : t_rev
  task automatic t_bias();
    logic [31:0] s;
    axi_wr(8'h08, 32'h0000_03E8);
    axi_wr(8'h00, 32'h0000_0002);
    set_in(32'sh0000_1388, 32'sh0000_0000, 32'sh0000_2710);
    wait_val(1'b0, 32'sh0000_02D0, s);
    chk(s, 32'h0000_02D0, "open speed bias");
    axi_wr(8'h00, 32'h0000_0000);
    wait_val(1'b0, 32'sh0000_0258, s);
    chk(s, 32'h0000_0258, "bias ignored");
    $display("test bias done");
  endtask : t_bias
  task automatic t_splice();
    logic [31:0] s;
    int n;
    axi_wr(8'h04, 32'h0000_07D0);
    axi_wr(8'h1C, 32'h0000_1388);
    axi_wr(8'h00, 32'h0000_0009);
    axi_wr(8'h3C, 32'h0504_024F);
    set_in(32'sh0000_1388, 32'sh0000_0BB8, 32'sh0000_2710);
    wait_val(1'b0, 32'sh0000_03C0, s);
    @(posedge aclk);
    near_full <= 1'b1;
    @(posedge aclk);
    near_full <= 1'b0;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (dinit !== 1'b1 && n < 10);
    chk(dinit_pct, 32'h0000_1388, "bobbin preset");
    chk({pblk, dhold}, 2'b11, "pid blocked");
    @(negedge aclk);
    chk(dinit, 1'b0, "init pulse");
    wait_val(1'b0, 32'sh0000_05A0, s);
    chk(s, 32'h0000_05A0, "splice speed");
    @(posedge aclk);
    swap_done <= 1'b1;
    @(posedge aclk);
    swap_done <= 1'b0;
    wait_val(1'b0, 32'sh0000_03C0, s);
    chk(s, 32'h0000_03C0, "speed after splice");
    chk({pblk, dhold}, 2'b00, "pid resumed");
    $display("test splice done");
  endtask : t_splice
  task automatic t_torq();
    logic [31:0] s;
    axi_wr(8'h0C, 32'h0000_4E20);
    @(posedge aclk);
    ten_pct <= 32'sh0000_1388;
    fric_pct <= 32'sh0000_00C8;
    set_in(32'sh0000_1388, 32'sh0000_03E8, 32'sh0000_1F40);
    axi_wr(8'h00, 32'h0000_0004);
    wait_val(1'b1, 32'sh0000_2260, s);
    chk(s, 32'h0000_2260, "closed tension torque");
    axi_wr(8'h0C, 32'h0000_2710);
    axi_wr(8'h00, 32'h0000_0006);
    set_in(32'sh0000_1388, 32'sh0000_1388, 32'sh0000_1F40);
    wait_val(1'b1, 32'sh0000_1068, s);
    chk(s, 32'h0000_1068, "open tension torque");
    $display("test torque done");
  endtask : t_torq
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    end_sim();
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, near_full, swap_done} = 8'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    fwd_run = 1'b1;
    {main_pct, pid_pct, diam_pct} = {32'sh0, 32'sh0, 32'sh0000_2710};
    {ten_pct, fric_pct} = 64'h0;
    mismatches = 0;
    total_checks = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_regs();
    t_norm();
    t_rev();
    t_bias();
    t_splice();
    t_torq();
    end_sim();
  end
endmodule : tb_top

// ===== dv/wfs_splice_ctl.sv
`timescale 1ns/10ps
module wfs_splice_ctl #(
  parameter int DI_IDX = 0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic near_full,
  input wire logic swap_done,
  output logic [7:0] di_out
);
  logic splice_reg;
  ////////////////////////////////////////////////////////////////////////////////
  // on while the new bobbin is being wound; a bare level, so no glitch between frames
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      splice_reg <= 1'b0;
    end else if (near_full) begin
      splice_reg <= 1'b1;
    end else if (swap_done) begin
      splice_reg <= 1'b0;
    end
  end
  // other inputs carry other functions and stay off here
  always_comb begin
    di_out = 8'h00;
    di_out[DI_IDX] = splice_reg;
  end
endmodule : wfs_splice_ctl

// ===== pkg/wfs_consts.svh
`ifndef WFS_CONSTS_SVH
`define WFS_CONSTS_SVH
////////////////////////////////////////////////////////////////////////////////
// register byte offsets
`define WFS_OFS_CTRL 8'h00
`define WFS_OFS_SPLICE 8'h04
`define WFS_OFS_BIAS 8'h08
`define WFS_OFS_FFGAIN 8'h0C
`define WFS_OFS_MAXF 8'h10
`define WFS_OFS_MIND 8'h14
`define WFS_OFS_BOB0 8'h18
`define WFS_OFS_ACC 8'h28
`define WFS_OFS_DEC 8'h2C
`define WFS_OFS_STATUS 8'h30
`define WFS_OFS_SPEED 8'h34
`define WFS_OFS_TORQUE 8'h38
`define WFS_OFS_DIFLO 8'h3C
`define WFS_OFS_DIFHI 8'h40
////////////////////////////////////////////////////////////////////////////////
// field positions
`define WFS_CTRL_REV 0
`define WFS_CTRL_MODE_LSB 1
`define WFS_CTRL_BOB_LSB 3
////////////////////////////////////////////////////////////////////////////////
// reset values and codes; levels in hundredths of a unit
`define WFS_CTRL_RST 32'h0000_0001
`define WFS_ZERO_RST 32'h0000_0000
`define WFS_FFGAIN_RST 32'h0000_2710
`define WFS_MAXF_RST 32'h0000_1770
`define WFS_MIND_RST 32'h0000_07D0
`define WFS_BOB_RST 32'h0000_2710
`define WFS_RAMP_RST 32'h0000_00C8
`define WFS_DIFLO_RST 32'h0504_0201
`define WFS_DIFHI_RST 32'h090C_0B0A
`define WFS_FUNC_SPLICE 8'h4F
`define WFS_PCT_FULL 32'sh0000_2710
`define WFS_RESP_OKAY 2'b00
`define WFS_RESP_SLVERR 2'b10
////////////////////////////////////////////////////////////////////////////////
// timing
`define WFS_CLK_PERIOD_NS 10
`define WFS_TICK_NS 1000000
`define WFS_TICK_CYC (`WFS_TICK_NS / `WFS_CLK_PERIOD_NS)
`define WFS_TICKS_PER_CS 10
`endif

// ===== pkg/wfs_pkg.sv
`include "wfs_consts.svh"
package wfs_pkg;
  typedef enum logic [1:0] {
    WFS_CL_SPEED = 2'b00,
    WFS_OL_SPEED = 2'b01,
    WFS_CL_TENSION = 2'b10,
    WFS_OL_TENSION = 2'b11
  } wfs_mode_t;

  typedef struct packed {
    logic [31:0] tick_cnt;
    logic signed [31:0] current;
  } wfs_ramp_st_t;

  typedef struct packed {
    logic awready, wready, arready, aw_full, w_full, bvalid, rvalid;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, ctrl, splice_lvl, bias, ff_gain, max_freq, min_diam;
    logic [31:0] accel_ramp_time, dec_time;
    logic [3:0][31:0] bobbin;
    logic [7:0][7:0] di_func;
    logic splice, reverse, clamp, diam_init;
    logic signed [31:0] target, torque, diam_init_val, acc_step, dec_step;
  } wfs_top_st_t;

  // saturate instead of wrap
  function automatic logic signed [31:0] wfs_sat(input logic signed [63:0] v);
    if (v > 64'sh0000_0000_7FFF_FFFF) return 32'sh7FFF_FFFF;
    if (v < -64'sh0000_0000_8000_0000) return 32'sh8000_0000;
    return v[31:0];
  endfunction : wfs_sat

  function automatic logic signed [31:0] wfs_add(input logic signed [31:0] a, b);
    return wfs_sat(64'(a) + 64'(b));
  endfunction : wfs_add

  // divide by zero gives zero, never a spike on the output
  function automatic logic signed [31:0] wfs_muldiv(input logic signed [31:0] a, b, c);
    if (c == 32'sh0000_0000) return 32'sh0000_0000;
    return wfs_sat((64'(a) * 64'(b)) / 64'(c));
  endfunction : wfs_muldiv

  function automatic logic [31:0] wfs_strb(input logic [31:0] old, d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) if (s[i]) r[8*i +: 8] = d[8*i +: 8];
    return r;
  endfunction : wfs_strb
endpackage : wfs_pkg

// ===== pkg/wfs_ramp_if.sv
`timescale 1ns/10ps
interface wfs_ramp_if;
  logic signed [31:0] target;
  logic signed [31:0] acc_step;
  logic signed [31:0] dec_step;
  logic signed [31:0] current;
  modport ctl (output target, output acc_step, output dec_step, input current);
  modport rmp (input target, input acc_step, input dec_step, output current);
endinterface : wfs_ramp_if

// ===== rtl/wfs_ramp.sv
`timescale 1ns/10ps
`include "wfs_consts.svh"
module wfs_ramp
  import wfs_pkg::*;
#(
  parameter int TICK_CYC = `WFS_TICK_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  wfs_ramp_if.rmp rif
);
  wfs_ramp_st_t q, n;
  logic signed [32:0] diff;

  // one step per tick; rising uses accel step, falling uses decel step
  always_comb begin
    n = q;
    diff = 33'(rif.target) - 33'(q.current);
    if (q.tick_cnt >= 32'(TICK_CYC - 1)) begin
      n.tick_cnt = 32'h0000_0000;
      if (diff > 33'(rif.acc_step)) begin
        n.current = q.current + rif.acc_step;
      end else if (diff < -33'(rif.dec_step)) begin
        n.current = q.current - rif.dec_step;
      end else begin
        n.current = rif.target;
      end
    end else begin
      n.tick_cnt = q.tick_cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign rif.current = q.current;
endmodule : wfs_ramp

// ===== rtl/wfs_top.sv
// How it works
// - final speed passes through accel/decel ramp
// - reverse enable: negative sum runs reverse |PID|
// - reverse disabled: negative sum clamps to zero
// - splice input blocks PID, uses splice formula
// - splice speed is main plus main times level
// - splice percent converts to hertz via max frequency
// - splice start loads selected bobbin diameter
// - splice speed scaled by min over bobbin
// - splice off resumes PID and diameter path
// - speed bias added only in open speed mode
// - closed tension torque uses PID and diameter
// - open tension torque uses friction, no PID
// - tension command scaled by feedforward gain
// - normal speed is min over estimated diameter
// - speed plus PID percent converts to hertz
`timescale 1ns/10ps
`include "wfs_consts.svh"
module wfs_top
  import wfs_pkg::*;
#(
  parameter int TICK_CYC = `WFS_TICK_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] di_in,
  input wire logic fwd_run,
  input wire logic signed [31:0] main_speed_pct,
  input wire logic signed [31:0] pid_out_pct,
  input wire logic signed [31:0] diam_est_pct,
  input wire logic signed [31:0] tension_cmd_pct,
  input wire logic signed [31:0] friction_loss_pct,
  output logic signed [31:0] speed_cmd_hz,
  output logic run_reverse,
  output logic signed [31:0] torque_cmd_pct,
  output logic pid_block,
  output logic diam_calc_hold,
  output logic diam_init,
  output logic signed [31:0] diam_init_pct
);
  localparam wfs_top_st_t RST = '{
    ctrl: `WFS_CTRL_RST,
    ff_gain: `WFS_FFGAIN_RST,
    max_freq: `WFS_MAXF_RST,
    min_diam: `WFS_MIND_RST,
    accel_ramp_time: `WFS_RAMP_RST,
    dec_time: `WFS_RAMP_RST,
    bobbin: {4{`WFS_BOB_RST}},
    di_func: {`WFS_DIFHI_RST, `WFS_DIFLO_RST},
    default: '0
  };

  wfs_top_st_t q, n;
  wfs_mode_t mode;
  logic [7:0] splice_hit;
  logic splice_now;
  logic signed [31:0] speed_plus_pid_sum, msc, hz, bob, ff, pid_abs;
  logic [32:0] wr_look;
  logic [32:0] rd_look;

  wfs_ramp_if rif ();

  wfs_ramp #(.TICK_CYC(TICK_CYC)) u_ramp (
    .aclk(aclk),
    .aresetn(aresetn),
    .rif(rif)
  );

  //////////////////////////////////////////////////////////////////////////////
  // splice function on any input whose function code selects it
  for (genvar g = 0; g < 8; g++) begin : g_di
    assign splice_hit[g] = di_in[g] && (q.di_func[g] == `WFS_FUNC_SPLICE);
  end
  assign splice_now = |splice_hit;

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [32:0] rd_mux(input wfs_top_st_t s, input logic [7:0] a,
                                         input logic signed [31:0] spd);
    logic [32:0] r;
    r = {1'b0, `WFS_ZERO_RST};
    case (a)
      `WFS_OFS_CTRL: r[31:0] = s.ctrl;
      `WFS_OFS_SPLICE: r[31:0] = s.splice_lvl;
      `WFS_OFS_BIAS: r[31:0] = s.bias;
      `WFS_OFS_FFGAIN: r[31:0] = s.ff_gain;
      `WFS_OFS_MAXF: r[31:0] = s.max_freq;
      `WFS_OFS_MIND: r[31:0] = s.min_diam;
      `WFS_OFS_ACC: r[31:0] = s.accel_ramp_time;
      `WFS_OFS_DEC: r[31:0] = s.dec_time;
      `WFS_OFS_STATUS: r[31:0] = {29'h0000_0000, s.clamp, s.reverse, s.splice};
      `WFS_OFS_SPEED: r[31:0] = spd;
      `WFS_OFS_TORQUE: r[31:0] = s.torque;
      `WFS_OFS_DIFLO: r[31:0] = s.di_func[3:0];
      `WFS_OFS_DIFHI: r[31:0] = s.di_func[7:4];
      default: r[32] = 1'b1;
    endcase
    for (int i = 0; i < 4; i++) begin
      if (a == 8'(`WFS_OFS_BOB0 + 4 * i)) r = {1'b0, s.bobbin[i]};
    end
    return r;
  endfunction : rd_mux

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    n = q;
    mode = wfs_mode_t'(q.ctrl[`WFS_CTRL_MODE_LSB +: 2]);
    bob = q.bobbin[q.ctrl[`WFS_CTRL_BOB_LSB +: 2]];
    wr_look = rd_mux(q, q.aw_addr, rif.current);
    rd_look = rd_mux(q, s_axi_araddr, rif.current);
    // write channel: address and data in either order, response after both
    if (s_axi_awvalid && q.awready) begin
      n.aw_full = 1'b1;
      n.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      n.w_full = 1'b1;
      n.w_data = s_axi_wdata;
      n.w_strb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) n.bvalid = 1'b0;
    if (q.aw_full && q.w_full && !q.bvalid) begin
      n.aw_full = 1'b0;
      n.w_full = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = wr_look[32] ? `WFS_RESP_SLVERR : `WFS_RESP_OKAY;
      case (q.aw_addr)
        `WFS_OFS_CTRL: n.ctrl = wfs_strb(q.ctrl, q.w_data, q.w_strb);
        `WFS_OFS_SPLICE: n.splice_lvl = wfs_strb(q.splice_lvl, q.w_data, q.w_strb);
        `WFS_OFS_BIAS: n.bias = wfs_strb(q.bias, q.w_data, q.w_strb);
        `WFS_OFS_FFGAIN: n.ff_gain = wfs_strb(q.ff_gain, q.w_data, q.w_strb);
        `WFS_OFS_MAXF: n.max_freq = wfs_strb(q.max_freq, q.w_data, q.w_strb);
        `WFS_OFS_MIND: n.min_diam = wfs_strb(q.min_diam, q.w_data, q.w_strb);
        `WFS_OFS_ACC: n.accel_ramp_time = wfs_strb(q.accel_ramp_time, q.w_data, q.w_strb);
        `WFS_OFS_DEC: n.dec_time = wfs_strb(q.dec_time, q.w_data, q.w_strb);
        `WFS_OFS_DIFLO: n.di_func[3:0] = wfs_strb(q.di_func[3:0], q.w_data, q.w_strb);
        `WFS_OFS_DIFHI: n.di_func[7:4] = wfs_strb(q.di_func[7:4], q.w_data, q.w_strb);
        default: n.ctrl = q.ctrl;
      endcase
      for (int i = 0; i < 4; i++) begin
        if (q.aw_addr == 8'(`WFS_OFS_BOB0 + 4 * i)) begin
          n.bobbin[i] = wfs_strb(q.bobbin[i], q.w_data, q.w_strb);
        end
      end
    end
    // read channel: one read at a time, data held until rready
    if (q.rvalid && s_axi_rready) n.rvalid = 1'b0;
    if (s_axi_arvalid && q.arready) begin
      n.rvalid = 1'b1;
      n.rdata = rd_look[31:0];
      n.rresp = rd_look[32] ? `WFS_RESP_SLVERR : `WFS_RESP_OKAY;
    end
    n.awready = !n.aw_full;
    n.wready = !n.w_full;
    n.arready = !n.rvalid;

    ////////////////////////////////////////////////////////////////////////////
    // final speed; one register stage, ramp follows
    n.splice = splice_now;
    n.diam_init = splice_now && !q.splice;
    if (splice_now && !q.splice) n.diam_init_val = bob;
    pid_abs = (pid_out_pct == 32'sh8000_0000) ? 32'sh7FFF_FFFF : -pid_out_pct;
    if (pid_out_pct >= 32'sh0000_0000) pid_abs = pid_out_pct;
    speed_plus_pid_sum = wfs_add(main_speed_pct, pid_out_pct);
    if (mode == WFS_OL_SPEED) speed_plus_pid_sum = wfs_add(speed_plus_pid_sum, q.bias);
    msc = wfs_add(main_speed_pct, wfs_muldiv(main_speed_pct, q.splice_lvl, `WFS_PCT_FULL));
    n.reverse = 1'b0;
    n.clamp = 1'b0;
    if (splice_now) begin
      hz = wfs_muldiv(msc, q.max_freq, `WFS_PCT_FULL);
      n.target = wfs_muldiv(hz, q.min_diam, bob);
    end else if (fwd_run && speed_plus_pid_sum < 32'sh0000_0000 && q.ctrl[`WFS_CTRL_REV]) begin
      hz = wfs_muldiv(pid_abs, q.max_freq, `WFS_PCT_FULL);
      n.target = wfs_muldiv(hz, q.min_diam, diam_est_pct);
      n.reverse = 1'b1;
    end else if (fwd_run && speed_plus_pid_sum < 32'sh0000_0000) begin
      hz = 32'sh0000_0000;
      n.target = 32'sh0000_0000;
      n.clamp = 1'b1;
    end else begin
      hz = wfs_muldiv(speed_plus_pid_sum, q.max_freq, `WFS_PCT_FULL);
      n.target = wfs_muldiv(hz, q.min_diam, diam_est_pct);
    end
    // ramp step per 1 ms tick from ramp time in hundredths of a second
    n.acc_step = wfs_muldiv(q.max_freq, 32'sh0000_0001, q.accel_ramp_time * `WFS_TICKS_PER_CS);
    n.dec_step = wfs_muldiv(q.max_freq, 32'sh0000_0001, q.dec_time * `WFS_TICKS_PER_CS);
    if (q.accel_ramp_time == `WFS_ZERO_RST) n.acc_step = q.max_freq;
    if (q.dec_time == `WFS_ZERO_RST) n.dec_step = q.max_freq;
    if (n.acc_step < 32'sh0000_0001) n.acc_step = 32'sh0000_0001;
    if (n.dec_step < 32'sh0000_0001) n.dec_step = 32'sh0000_0001;

    ////////////////////////////////////////////////////////////////////////////
    // torque front end; speed modes leave the torque command at zero
    ff = wfs_muldiv(tension_cmd_pct, q.ff_gain, `WFS_PCT_FULL);
    unique case (mode)
      WFS_CL_TENSION: begin
        n.torque = wfs_muldiv(wfs_add(ff, splice_now ? 32'sh0000_0000 : pid_out_pct),
                              diam_est_pct, `WFS_PCT_FULL);
      end
      WFS_OL_TENSION: begin
        n.torque = wfs_add(wfs_muldiv(ff, diam_est_pct, `WFS_PCT_FULL),
                           friction_loss_pct);
      end
      WFS_CL_SPEED, WFS_OL_SPEED: n.torque = 32'sh0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= RST;
    end else begin
      q <= n;
    end
  end

  assign rif.target = q.target;
  assign rif.acc_step = q.acc_step;
  assign rif.dec_step = q.dec_step;

  //////////////////////////////////////////////////////////////////////////////
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bresp = q.bresp;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_arready = q.arready;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rvalid = q.rvalid;
  assign speed_cmd_hz = rif.current;
  assign run_reverse = q.reverse;
  assign torque_cmd_pct = q.torque;
  assign pid_block = q.splice;
  assign diam_calc_hold = q.splice;
  assign diam_init = q.diam_init;
  assign diam_init_pct = q.diam_init_val;

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_clamp_zero_target: assert property (
    q.clamp |-> (q.target == 32'sh0000_0000) && !q.reverse && $past(fwd_run))
    else $error("clamp without zero target");
  a_reverse_cause: assert property (
    q.reverse |-> $past(q.ctrl[`WFS_CTRL_REV]) && $past(fwd_run) && !q.splice)
    else $error("reverse without enable and forward run");
  a_splice_blocks_pid: assert property (
    $past(splice_now) |-> pid_block && diam_calc_hold && !run_reverse && !q.clamp)
    else $error("splice did not block pid");
  a_diam_init_load: assert property (
    $rose(q.splice) |-> diam_init && (diam_init_pct == $past(bob)))
    else $error("bobbin diameter not loaded at splice start");
  a_diam_init_once: assert property (
    diam_init |=> !diam_init)
    else $error("diameter load longer than one cycle");
  a_splice_resume: assert property (
    $fell(q.splice) |-> !$past(splice_now) && !diam_calc_hold && !diam_init)
    else $error("pid not resumed after splice");
  a_ramp_rise_bound: assert property (
    (speed_cmd_hz > $past(speed_cmd_hz)) |->
      (speed_cmd_hz - $past(speed_cmd_hz)) <= $past(rif.acc_step))
    else $error("speed stepped faster than accel ramp");
  a_ramp_fall_bound: assert property (
    (speed_cmd_hz < $past(speed_cmd_hz)) |->
      ($past(speed_cmd_hz) - speed_cmd_hz) <= $past(rif.dec_step))
    else $error("speed stepped faster than decel ramp");
  a_bresp_after_both: assert property (
    $rose(s_axi_bvalid) |-> $past(q.aw_full) && $past(q.w_full))
    else $error("write response before address and data");
  a_rvalid_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before rready");
  a_speed_mode_torque: assert property (
    $past(mode == WFS_OL_SPEED) || $past(mode == WFS_CL_SPEED) |-> torque_cmd_pct == 0)
    else $error("torque command in speed mode");

  //////////////////////////////////////////////////////////////////////////////
  // bus bookkeeping; ready must drop while a transfer is parked
  a_awready_busy: assert property (
    q.aw_full |-> !s_axi_awready)
    else $error("awready high while address held");
  a_wready_busy: assert property (
    q.w_full |-> !s_axi_wready)
    else $error("wready high while data held");
  a_commit_ready: assert property (
    $rose(s_axi_bvalid) |-> s_axi_awready && s_axi_wready)
    else $error("write channels not reopened at commit");
  a_arready_busy: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("arready high while read data pending");
  a_rvalid_after_ar: assert property (
    $rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
    else $error("read data without address");

  // compute path; flags sit one register stage behind the inputs
  a_speed_tick_only: assert property (
    $changed(speed_cmd_hz) |-> $past(u_ramp.q.tick_cnt) == 32'(TICK_CYC - 1))
    else $error("speed moved between ticks");
  a_reverse_needs_neg: assert property (
    q.reverse |-> $past(speed_plus_pid_sum) < 32'sh0000_0000)
    else $error("reverse with non-negative sum");
  a_clamp_needs_off: assert property (
    q.clamp |-> !$past(q.ctrl[`WFS_CTRL_REV]) && $past(speed_plus_pid_sum) < 32'sh0000_0000)
    else $error("clamp with reverse enabled or positive sum");
  a_diam_init_splice: assert property (
    diam_init |-> pid_block)
    else $error("diameter load outside splice");
  a_diam_init_held: assert property (
    !diam_init |-> $stable(diam_init_pct))
    else $error("bobbin diameter changed without load");
  a_pid_block_follows: assert property (
    !$past(splice_now) |-> !pid_block)
    else $error("pid still blocked after splice off");
endmodule : wfs_top
